// ### hw/clock_switch_pkg.sv
// ============================================================
// Shared constants for the clock source switch block
// ============================================================
// Holds register offsets, field positions, reset values,
// write masks and timing counts; assumes a 25 MHz bus clock.
package clock_switch_pkg;

  // ==========================================================
  // Register byte offsets on the bus
  // ==========================================================
  localparam logic [7:0] OFS_SUPPLY_MODE = 8'h00;
  localparam logic [7:0] OFS_OSC_MODE = 8'h04;
  localparam logic [7:0] OFS_OSC_RUN = 8'h08;
  localparam logic [7:0] OFS_SYS_CLOCK = 8'h0C;
  localparam logic [7:0] OFS_SUBCLK_SEL = 8'h10;
  localparam logic [7:0] OFS_SETTLE_SEL = 8'h14;
  localparam logic [7:0] OFS_SETTLE_STAT = 8'h18;

  // ==========================================================
  // Field positions
  // ==========================================================
  // subsystem_supply_mode
  localparam int RTC_LOW_POWER_BIT = 7;
  localparam int INTERVAL_TIMER_LOWOSC_BIT = 4;
  localparam int HI_PRECISION_BIT = 0;
  // oscillator_mode_control
  localparam int MAIN_EXT_CLK_BIT = 7;
  localparam int MAIN_OSC_SELECT_BIT = 6;
  localparam int SUB_EXT_CLK_BIT = 5;
  localparam int SUB_OSC_SELECT_BIT = 4;
  localparam int CRYSTAL_PIN_SELECT_BIT = 3;
  localparam int SUB_AMP_SEL1_BIT = 2;
  localparam int SUB_AMP_SEL0_BIT = 1;
  localparam int MAIN_AMP_HIGH_BIT = 0;
  // oscillator_run_control
  localparam int MAIN_OSC_STOP_BIT = 7;
  localparam int SUB_OSC_STOP_BIT = 6;
  localparam int MID_OSC_ENABLE_BIT = 1;
  localparam int HI_OSC_STOP_BIT = 0;
  // system_clock_control
  localparam int SUBCLK_STATUS_BIT = 7;
  localparam int CPU_CLOCK_SELECT_BIT = 6;
  localparam int MAIN_CLOCK_STATUS_BIT = 5;
  localparam int MAIN_OSC_SELECT0_BIT = 4;
  localparam int MAIN_OSC_STATUS_BIT = 1;
  localparam int MAIN_OSC_SELECT1_BIT = 0;
  // subclock_source_select
  localparam int LOW_OSC_SELECT_BIT = 0;

  // ==========================================================
  // Writable masks; other bits read zero except supply bit 0 and system clock bits 7, 5, 1, which read status
  // ==========================================================
  localparam logic [7:0] MASK_SUPPLY_MODE = 8'h90;
  localparam logic [7:0] MASK_OSC_MODE = 8'hFF;
  localparam logic [7:0] MASK_OSC_RUN = 8'hC3;
  localparam logic [7:0] MASK_SYS_CLOCK = 8'h51;
  localparam logic [7:0] MASK_SUBCLK_SEL = 8'h01;
  localparam logic [7:0] MASK_SETTLE_SEL = 8'h07;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] RST_SUPPLY_MODE = 8'h00;
  localparam logic [7:0] RST_OSC_MODE = 8'h00;
  localparam logic [7:0] RST_OSC_RUN = 8'hC0;
  localparam logic [7:0] RST_SYS_CLOCK = 8'h00;
  localparam logic [7:0] RST_SUBCLK_SEL = 8'h00;
  localparam logic [7:0] RST_SETTLE_SEL = 8'h07;

  // ==========================================================
  // Bus answers and the one write that may set the mode register
  // ==========================================================
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] STRB_LOW_BYTE = 4'h1;

  // ==========================================================
  // Source codes driven to the clock multiplexer
  // ==========================================================
  localparam logic [1:0] SRC_HI_OSC = 2'h0;
  localparam logic [1:0] SRC_MID_OSC = 2'h1;
  localparam logic [1:0] SRC_HIGH_SYS = 2'h2;
  localparam logic [1:0] SRC_SUBSYS = 2'h3;

  // ==========================================================
  // Timing: dead time with the clock gated while switching
  // ==========================================================
  localparam int CLK_PERIOD_NS = 40;
  localparam int SWITCH_GAP_NS = 200;
  localparam int SWITCH_GAP_CYCLES = (SWITCH_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Settle counter: log2 of crystal edges per status bit
  // ==========================================================
  localparam int SETTLE_MAX_LOG2 = 18;
  localparam int SETTLE_LOG2 [8] = '{8, 9, 10, 11, 13, 15, 17, 18};

endpackage

// ### hw/settle_counter.sv
// ============================================================
// Main crystal settle counter
// ============================================================
// Counts rising edges of the main crystal clock pin while the
// crystal runs; the pin is asynchronous to aclk.
`timescale 1ns/1ps

module settle_counter #(
  parameter int COUNT_WIDTH = clock_switch_pkg::SETTLE_MAX_LOG2 + 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic osc_pin,
  input wire logic [2:0] time_select,
  output logic [7:0] status,
  output logic settled
);

  initial begin
    if (COUNT_WIDTH < clock_switch_pkg::SETTLE_MAX_LOG2 + 1) begin
      $error("settle_counter: COUNT_WIDTH too small");
    end
  end

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic [COUNT_WIDTH-1:0] count;
    logic [7:0] status;
    logic settled;
  } state_type;

  state_type cur_q;
  state_type nxt_d;

  // Single edge-count bits decoded for the status bits and the selected wait
  function automatic logic reached(input logic [COUNT_WIDTH-1:0] cnt, input int idx);
    reached = cnt[clock_switch_pkg::SETTLE_LOG2[idx]];
  endfunction

  // Edge count saturates at the top step, so only status bit 0 stays put; bits 7 to 1 read zero there
  always_comb begin
    nxt_d = cur_q;
    nxt_d.sync1 = osc_pin;
    nxt_d.sync2 = cur_q.sync1;
    nxt_d.prev = cur_q.sync2;
    if (!run) begin
      nxt_d.count = '0;
    end else if (cur_q.sync2 && !cur_q.prev && !reached(cur_q.count, 7)) begin
      nxt_d.count = cur_q.count + 1'b1;
    end
    for (int i = 0; i < 8; i++) begin
      nxt_d.status[7-i] = run && reached(cur_q.count, i);
    end
    nxt_d.settled = run && reached(cur_q.count, int'(time_select));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_q <= '0;
    end else begin
      cur_q <= nxt_d;
    end
  end

  assign status = cur_q.status;
  assign settled = cur_q.settled;

endmodule

// ### hw/clock_source_switch.sv
// ============================================================
// CPU clock source selection and oscillator control
// ============================================================
// Contract
// - cpu_clock_select set to 1 moves the CPU clock to the subsystem clock.
// - main_osc_select bits are frozen while cpu_clock_select is 1.
// - subclk_status reads 1 once the CPU runs from the subsystem clock.
// - Both main_osc_select bits 0 select the high-speed on-chip oscillator.
// - On the high-speed oscillator both main status bits read 0.
// - main_osc_select0 at 1 selects the high-speed system clock.
// - hi_osc_stop 0 runs the high-speed oscillator, 1 stops it.
// - mid_osc_enable 1 runs the middle-speed oscillator, 0 stops it.
// - Clearing sub_osc_stop starts the sub crystal; external clock applied first.
// - Clearing main_osc_stop starts the main crystal; external clock applied first.
// - low_osc_select 1 starts the low-speed oscillator; subclk_status checked first.
// - Mode register takes one byte write after reset, later writes ignored.
// - sub_osc_select picks sub crystal; with sub_ext_clk, external sub input.
// - crystal_pin_select 1 uses the sub crystal pins, 0 the main crystal.
// - Both sub_amp_sel bits 0 give the default low-power oscillation setting.
// - Three-bit settle select chooses the main crystal stabilisation wait.
// - Settle status bits fill progressively; software polls the upper ones. Here each bit copies one edge-count bit; bits 7 to 1 clear again, bit 0 holds.
// - interval_timer_lowosc 1 feeds the low-speed oscillator to the interval timer.
// - rtc_low_power 0 lets peripherals run on the subsystem clock in standby.
// - main_osc_select0 0 and select1 1 select the middle-speed oscillator.
// - main_clock_status reads 1 once the main clock is the high-speed system clock.
// ============================================================
// Assumes an AXI4-Lite master on aclk and a glitch-free clock
// multiplexer that obeys clk_source and clk_gate_enable.
//
// Chosen here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps

module clock_source_switch #(
  parameter int GAP_CYCLES = clock_switch_pkg::SWITCH_GAP_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic main_crystal_circuit,
  input wire logic hi_precision_in,
  output logic hi_osc_run,
  output logic mid_osc_run,
  output logic low_osc_run,
  output logic main_xtal_enable,
  output logic main_ext_enable,
  output logic main_amp_high,
  output logic sub_xtal_enable,
  output logic sub_ext_enable,
  output logic [1:0] sub_amp_sel,
  output logic sub_crystal_pins,
  output logic timer_uses_lowosc,
  output logic periph_sub_in_standby,
  output logic [1:0] clk_source,
  output logic sub_uses_lowosc,
  output logic clk_gate_enable,
  output logic main_settled
);

  initial begin
    if (GAP_CYCLES < 1 || GAP_CYCLES > 255) begin
      $error("clock_source_switch: GAP_CYCLES out of range");
    end
  end

  typedef enum logic [1:0] {SW_IDLE, SW_GATE_OFF, SW_GATE_ON} switch_state_type;

  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] supply_mode;
    logic [7:0] osc_mode;
    logic osc_mode_locked;
    logic [7:0] osc_run;
    logic cpu_sel;
    logic sel0;
    logic sel1;
    logic [7:0] subclk_sel;
    logic [7:0] settle_sel;
    logic prec_sync1;
    logic prec_sync2;
    switch_state_type sw_state;
    logic [7:0] gap_cnt;
    logic on_sub;
    logic [1:0] main_act;
    logic [1:0] src;
    logic gate;
  } state_type;

  state_type cur_q;
  state_type nxt_d;
  logic [7:0] settle_status;
  logic settled;
  logic [1:0] main_want;
  logic [7:0] sys_clock_rd;
  logic wr_fire;

  // ==========================================================
  // Main crystal settle counter
  // ==========================================================
  settle_counter #(
    .COUNT_WIDTH(clock_switch_pkg::SETTLE_MAX_LOG2 + 1)
  ) u_settle (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(main_xtal_enable),
    .osc_pin(main_crystal_circuit),
    .time_select(cur_q.settle_sel[2:0]),
    .status(settle_status),
    .settled(settled)
  );

  // Main clock wanted by the select bits
  function automatic logic [1:0] main_decode(input logic s0, input logic s1);
    if (s0) begin
      main_decode = clock_switch_pkg::SRC_HIGH_SYS;
    end else if (s1) begin
      main_decode = clock_switch_pkg::SRC_MID_OSC;
    end else begin
      main_decode = clock_switch_pkg::SRC_HI_OSC;
    end
  endfunction

  // Merged clock source code seen by the multiplexer
  function automatic logic [1:0] cpu_decode(input logic sub, input logic [1:0] main_src);
    cpu_decode = sub ? clock_switch_pkg::SRC_SUBSYS : main_src;
  endfunction

  assign main_want = main_decode(cur_q.sel0, cur_q.sel1);
  assign wr_fire = cur_q.aw_got && cur_q.w_got && !cur_q.bvalid;

  // Status bits come from what really drives the clock
  always_comb begin
    sys_clock_rd = '0;
    sys_clock_rd[clock_switch_pkg::SUBCLK_STATUS_BIT] = cur_q.on_sub;
    sys_clock_rd[clock_switch_pkg::CPU_CLOCK_SELECT_BIT] = cur_q.cpu_sel;
    sys_clock_rd[clock_switch_pkg::MAIN_CLOCK_STATUS_BIT] =
      (cur_q.main_act == clock_switch_pkg::SRC_HIGH_SYS);
    sys_clock_rd[clock_switch_pkg::MAIN_OSC_SELECT0_BIT] = cur_q.sel0;
    sys_clock_rd[clock_switch_pkg::MAIN_OSC_STATUS_BIT] =
      (cur_q.main_act == clock_switch_pkg::SRC_MID_OSC);
    sys_clock_rd[clock_switch_pkg::MAIN_OSC_SELECT1_BIT] = cur_q.sel1;
  end

  // ==========================================================
  // Next state: bus slave, registers and switch sequencer
  // ==========================================================
  always_comb begin
    logic [7:0] wd;
    logic [7:0] sm;
    wd = '0;
    sm = '0;
    nxt_d = cur_q;
    nxt_d.prec_sync1 = hi_precision_in;
    nxt_d.prec_sync2 = cur_q.prec_sync1;

    // Address and data channels are taken in either order
    if (s_axi_awvalid && !cur_q.aw_got) begin
      nxt_d.aw_got = 1'b1;
      nxt_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !cur_q.w_got) begin
      nxt_d.w_got = 1'b1;
      nxt_d.w_data = s_axi_wdata[7:0];
      nxt_d.w_strb = s_axi_wstrb;
    end
    if (cur_q.bvalid && s_axi_bready) begin
      nxt_d.bvalid = 1'b0;
    end

    // Register write; only byte lane 0 carries the eight bits
    if (wr_fire) begin
      nxt_d.aw_got = 1'b0;
      nxt_d.w_got = 1'b0;
      nxt_d.bvalid = 1'b1;
      nxt_d.bresp = clock_switch_pkg::RESP_OKAY;
      wd = cur_q.w_data;
      if (cur_q.aw_addr == clock_switch_pkg::OFS_SUPPLY_MODE) begin
        if (cur_q.w_strb[0]) begin
          nxt_d.supply_mode = wd & clock_switch_pkg::MASK_SUPPLY_MODE;
        end
      end else if (cur_q.aw_addr == clock_switch_pkg::OFS_OSC_MODE) begin
        // A wider or lock-time write leaves the mode as it was
        if (!cur_q.osc_mode_locked && cur_q.w_strb == clock_switch_pkg::STRB_LOW_BYTE) begin
          nxt_d.osc_mode = wd & clock_switch_pkg::MASK_OSC_MODE;
          nxt_d.osc_mode_locked = 1'b1;
        end
      end else if (cur_q.aw_addr == clock_switch_pkg::OFS_OSC_RUN) begin
        if (cur_q.w_strb[0]) begin
          nxt_d.osc_run = wd & clock_switch_pkg::MASK_OSC_RUN;
        end
      end else if (cur_q.aw_addr == clock_switch_pkg::OFS_SYS_CLOCK) begin
        if (cur_q.w_strb[0]) begin
          nxt_d.cpu_sel = wd[clock_switch_pkg::CPU_CLOCK_SELECT_BIT];
          // Frozen while the CPU select bit stands at 1
          if (!cur_q.cpu_sel) begin
            nxt_d.sel0 = wd[clock_switch_pkg::MAIN_OSC_SELECT0_BIT];
            nxt_d.sel1 = wd[clock_switch_pkg::MAIN_OSC_SELECT1_BIT];
          end
        end
      end else if (cur_q.aw_addr == clock_switch_pkg::OFS_SUBCLK_SEL) begin
        if (cur_q.w_strb[0]) begin
          nxt_d.subclk_sel = wd & clock_switch_pkg::MASK_SUBCLK_SEL;
        end
      end else if (cur_q.aw_addr == clock_switch_pkg::OFS_SETTLE_SEL) begin
        if (cur_q.w_strb[0]) begin
          nxt_d.settle_sel = wd & clock_switch_pkg::MASK_SETTLE_SEL;
        end
      end else if (cur_q.aw_addr != clock_switch_pkg::OFS_SETTLE_STAT) begin
        nxt_d.bresp = clock_switch_pkg::RESP_SLVERR;
      end
    end

    // Register read, one outstanding at a time
    if (cur_q.rvalid && s_axi_rready) begin
      nxt_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !cur_q.rvalid) begin
      nxt_d.rvalid = 1'b1;
      nxt_d.rresp = clock_switch_pkg::RESP_OKAY;
      sm = cur_q.supply_mode;
      sm[clock_switch_pkg::HI_PRECISION_BIT] = cur_q.prec_sync2;
      if (s_axi_araddr == clock_switch_pkg::OFS_SUPPLY_MODE) begin
        nxt_d.rdata = sm;
      end else if (s_axi_araddr == clock_switch_pkg::OFS_OSC_MODE) begin
        nxt_d.rdata = cur_q.osc_mode;
      end else if (s_axi_araddr == clock_switch_pkg::OFS_OSC_RUN) begin
        nxt_d.rdata = cur_q.osc_run;
      end else if (s_axi_araddr == clock_switch_pkg::OFS_SYS_CLOCK) begin
        nxt_d.rdata = sys_clock_rd;
      end else if (s_axi_araddr == clock_switch_pkg::OFS_SUBCLK_SEL) begin
        nxt_d.rdata = cur_q.subclk_sel;
      end else if (s_axi_araddr == clock_switch_pkg::OFS_SETTLE_SEL) begin
        nxt_d.rdata = cur_q.settle_sel;
      end else if (s_axi_araddr == clock_switch_pkg::OFS_SETTLE_STAT) begin
        nxt_d.rdata = settle_status;
      end else begin
        nxt_d.rdata = '0;
        nxt_d.rresp = clock_switch_pkg::RESP_SLVERR;
      end
    end

    // Gate the clock, change source during the dead time, ungate;
    // status moves only once the new source is really selected
    case (cur_q.sw_state)
      SW_IDLE: begin
        if (cur_q.cpu_sel != cur_q.on_sub || (!cur_q.cpu_sel && main_want != cur_q.main_act)) begin
          nxt_d.gate = 1'b0;
          nxt_d.gap_cnt = 8'(GAP_CYCLES);
          nxt_d.sw_state = SW_GATE_OFF;
        end
      end
      SW_GATE_OFF: begin
        if (cur_q.gap_cnt > 8'h01) begin
          nxt_d.gap_cnt = cur_q.gap_cnt - 8'h01;
        end else begin
          nxt_d.on_sub = cur_q.cpu_sel;
          if (!cur_q.cpu_sel) begin
            nxt_d.main_act = main_want;
          end
          nxt_d.src = cpu_decode(cur_q.cpu_sel, cur_q.cpu_sel ? cur_q.main_act : main_want);
          nxt_d.gap_cnt = 8'(GAP_CYCLES);
          nxt_d.sw_state = SW_GATE_ON;
        end
      end
      SW_GATE_ON: begin
        // New source settles at the mux before the gate reopens
        if (cur_q.gap_cnt > 8'h01) begin
          nxt_d.gap_cnt = cur_q.gap_cnt - 8'h01;
        end else begin
          nxt_d.gate = 1'b1;
          nxt_d.sw_state = SW_IDLE;
        end
      end
      default: begin
        nxt_d.sw_state = SW_IDLE;
      end
    endcase
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cur_q <= '0;
      cur_q.supply_mode <= clock_switch_pkg::RST_SUPPLY_MODE;
      cur_q.osc_mode <= clock_switch_pkg::RST_OSC_MODE;
      cur_q.osc_run <= clock_switch_pkg::RST_OSC_RUN;
      cur_q.subclk_sel <= clock_switch_pkg::RST_SUBCLK_SEL;
      cur_q.settle_sel <= clock_switch_pkg::RST_SETTLE_SEL;
      cur_q.bresp <= clock_switch_pkg::RESP_OKAY;
      cur_q.rresp <= clock_switch_pkg::RESP_OKAY;
      cur_q.sw_state <= SW_IDLE;
      cur_q.main_act <= clock_switch_pkg::SRC_HI_OSC;
      cur_q.src <= clock_switch_pkg::SRC_HI_OSC;
      cur_q.gate <= 1'b1;
    end else begin
      cur_q <= nxt_d;
    end
  end

  // ==========================================================
  // Bus outputs
  // ==========================================================
  assign s_axi_awready = !cur_q.aw_got;
  assign s_axi_wready = !cur_q.w_got;
  assign s_axi_bvalid = cur_q.bvalid;
  assign s_axi_bresp = cur_q.bresp;
  assign s_axi_arready = !cur_q.rvalid;
  assign s_axi_rvalid = cur_q.rvalid;
  assign s_axi_rresp = cur_q.rresp;
  assign s_axi_rdata = {24'h000000, cur_q.rdata};

  // ==========================================================
  // Oscillator enables and mode outputs
  // ==========================================================
  assign hi_osc_run = !cur_q.osc_run[clock_switch_pkg::HI_OSC_STOP_BIT];
  assign mid_osc_run = cur_q.osc_run[clock_switch_pkg::MID_OSC_ENABLE_BIT];
  // Timer use keeps the low-speed oscillator alive on its own
  assign low_osc_run = cur_q.subclk_sel[clock_switch_pkg::LOW_OSC_SELECT_BIT]
    || cur_q.supply_mode[clock_switch_pkg::INTERVAL_TIMER_LOWOSC_BIT];
  assign sub_uses_lowosc = cur_q.subclk_sel[clock_switch_pkg::LOW_OSC_SELECT_BIT];
  // Main circuit starts when the stop bit clears in the chosen mode
  assign main_xtal_enable = cur_q.osc_mode[clock_switch_pkg::MAIN_OSC_SELECT_BIT]
    && !cur_q.osc_mode[clock_switch_pkg::MAIN_EXT_CLK_BIT]
    && !cur_q.osc_run[clock_switch_pkg::MAIN_OSC_STOP_BIT];
  assign main_ext_enable = cur_q.osc_mode[clock_switch_pkg::MAIN_OSC_SELECT_BIT]
    && cur_q.osc_mode[clock_switch_pkg::MAIN_EXT_CLK_BIT]
    && !cur_q.osc_run[clock_switch_pkg::MAIN_OSC_STOP_BIT];
  assign main_amp_high = cur_q.osc_mode[clock_switch_pkg::MAIN_AMP_HIGH_BIT];
  assign sub_xtal_enable = cur_q.osc_mode[clock_switch_pkg::SUB_OSC_SELECT_BIT]
    && !cur_q.osc_mode[clock_switch_pkg::SUB_EXT_CLK_BIT]
    && !cur_q.osc_run[clock_switch_pkg::SUB_OSC_STOP_BIT];
  assign sub_ext_enable = cur_q.osc_mode[clock_switch_pkg::SUB_OSC_SELECT_BIT]
    && cur_q.osc_mode[clock_switch_pkg::SUB_EXT_CLK_BIT]
    && !cur_q.osc_run[clock_switch_pkg::SUB_OSC_STOP_BIT];
  // Zero on both bits is the default low-power drive
  assign sub_amp_sel = {cur_q.osc_mode[clock_switch_pkg::SUB_AMP_SEL1_BIT],
    cur_q.osc_mode[clock_switch_pkg::SUB_AMP_SEL0_BIT]};
  assign sub_crystal_pins = cur_q.osc_mode[clock_switch_pkg::CRYSTAL_PIN_SELECT_BIT];
  assign timer_uses_lowosc = cur_q.supply_mode[clock_switch_pkg::INTERVAL_TIMER_LOWOSC_BIT];
  assign periph_sub_in_standby = !cur_q.supply_mode[clock_switch_pkg::RTC_LOW_POWER_BIT];
  assign clk_source = cur_q.src;
  assign clk_gate_enable = cur_q.gate;
  assign main_settled = settled;

endmodule

// ### tb/clock_switch_assertions.sv
// Port checker for the clock source switch block
// Assumes only the top ports; bound at the foot of this file
`timescale 1ns/1ps
module clock_switch_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic main_xtal_enable,
  input wire logic main_ext_enable,
  input wire logic sub_xtal_enable,
  input wire logic sub_ext_enable,
  input wire logic [1:0] clk_source,
  input wire logic clk_gate_enable
);
  // ==========================================
  // Bus answers, switch timing and crystal enable exclusion
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence gate_drop; $fell(clk_gate_enable); endsequence
  chk_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
  chk_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("reserved read bits set");
  chk_gated_switch: assert property ($changed(clk_source) |-> !clk_gate_enable)
    else $error("source changed ungated");
  chk_gate_min: assert property (gate_drop |=> !clk_gate_enable)
    else $error("runt gate pulse");
  chk_main_excl: assert property (!(main_xtal_enable && main_ext_enable))
    else $error("main crystal and input both on");
  chk_sub_excl: assert property (!(sub_xtal_enable && sub_ext_enable))
    else $error("sub crystal and input both on");
endmodule
bind clock_source_switch clock_switch_checker u_chk (.aclk, .aresetn, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready,
  .main_xtal_enable, .main_ext_enable, .sub_xtal_enable, .sub_ext_enable, .clk_source,
  .clk_gate_enable);

// ### tb/crystal_model.sv
// Main resonator and precision flag seen from outside the block
// Assumes the enable outputs of the switch block
`timescale 1ns/1ps
module crystal_model (
  input wire logic run,
  output logic xtal,
  output logic hi_precision_in
);
  // ==========================================
  // Slow resonator, still while stopped
  initial begin
    hi_precision_in = 1'b1;
    xtal = 1'b0;
    forever #100 xtal = run ? ~xtal : 1'b0;
  end
endmodule

// ### tb/cpu_clock_source_switch_tb.sv
// Bench for the clock source switch; one resonator model
// Assumes AXI4-Lite at 25 MHz and the package offsets
`timescale 1ns/1ps
module cpu_clock_source_switch_tb;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [3:0] ws = 4'h1;
  wire [31:0] rd_q;
  wire [1:0] rsp, src, brs;
  wire [13:0] pins;
  wire awr, wr_r, bv, arr, rv, xt, hp, mx, me;
  int n_mismatch = 0, comparisons = 0;
  clock_source_switch dut (.aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(brs), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_q),
    .s_axi_rresp(rsp), .s_axi_rvalid(rv), .s_axi_rready(rry), .main_crystal_circuit(xt),
    .hi_precision_in(hp), .hi_osc_run(pins[13]), .mid_osc_run(pins[12]),
    .low_osc_run(pins[11]), .main_xtal_enable(mx), .main_ext_enable(me),
    .main_amp_high(pins[10]), .sub_xtal_enable(pins[9]), .sub_ext_enable(pins[8]),
    .sub_amp_sel(pins[7:6]), .sub_crystal_pins(pins[5]), .timer_uses_lowosc(pins[4]),
    .periph_sub_in_standby(pins[3]), .clk_source(src), .sub_uses_lowosc(pins[2]),
    .clk_gate_enable(pins[1]), .main_settled(pins[0]));
  crystal_model u_xtal (.run(mx | me), .xtal(xt), .hi_precision_in(hp));
  // ==========================================
  // Clock and checking helpers
  initial forever #20 aclk = ~aclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Readies are registered, so the negedge shows what the next edge samples
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_s, w_s, b_s;
    @(posedge aclk);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1;
    wv <= 1;
    bry <= 1;
    do begin
      @(negedge aclk);
      aw_s = awr;
      w_s = wr_r;
      b_s = bv;
      @(posedge aclk);
      if (aw_s) awv <= 0;
      if (w_s) wv <= 0;
    end while (!b_s);
    bry <= 0;
    chk(brs, clock_switch_pkg::RESP_OKAY);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] r);
    logic a_s, v_s;
    @(posedge aclk);
    ara <= a;
    arv <= 1;
    rry <= 1;
    do begin
      @(negedge aclk);
      a_s = arr;
      v_s = rv;
      @(posedge aclk);
      if (a_s) arv <= 0;
    end while (!v_s);
    rry <= 0;
    chk(rd_q, exp);
    chk(rsp, r);
  endtask
  // Gate drops just after the write; switch takes about eleven cycles
  task automatic sw(input logic [7:0] d, e, input logic [1:0] s, input logic g);
    wr(clock_switch_pkg::OFS_SYS_CLOCK, d);
    @(negedge aclk);
    chk(pins[1], !g);
    repeat (20) @(posedge aclk);
    rd(clock_switch_pkg::OFS_SYS_CLOCK, {24'h0, e}, 2'h0);
    chk(src, s);
    chk(pins[1], 1'b1);
  endtask
  task automatic wrap_up;
    if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Run needs about 60 us, most of it the settle wait
  initial begin
    #300000;
    n_mismatch++;
    wrap_up;
  end
  // ==========================================
  // Scenarios
  // Precision flag read last: it needs two edges through its synchroniser
  task automatic t_reset;
    @(negedge aclk);
    chk(pins, 14'h200A);
    chk(src, clock_switch_pkg::SRC_HI_OSC);
    rd(8'h08, 32'hC0, 2'h0);
    rd(8'h0C, 32'h00, 2'h0);
    rd(8'h1C, 32'h00, 2'h2);
    rd(8'h00, 32'h01, 2'h0);
  endtask
  // A wide write must not use up the one mode write
  task automatic t_setup;
    wr(8'h00, 8'hFF);
    rd(8'h00, 32'h91, 2'h0);
    ws <= 4'hF;
    wr(8'h04, 8'hC0);
    ws <= 4'h1;
    wr(8'h04, 8'h50);
    wr(8'h04, 8'h30);
    rd(8'h04, 32'h50, 2'h0);
    wr(8'h14, 8'h00);
    rd(8'h14, 32'h00, 2'h0);
    wr(8'h10, 8'h01);
    wr(8'h08, 8'h02);
    @(negedge aclk);
    chk(mx, 1'b1);
    chk(pins, 14'h3A16);
  endtask
  // Start, settle, select, confirm, then stop the old source
  task automatic t_switch;
    sw(8'h01, 8'h03, 2'h1, 1'b1);
    wait (pins[0]);
    rd(8'h18, 32'h80, 2'h0);
    sw(8'h10, 8'h30, 2'h2, 1'b1);
    wr(8'h08, 8'h00);
    @(negedge aclk);
    chk(pins[12], 1'b0);
    sw(8'h50, 8'hF0, 2'h3, 1'b1);
    sw(8'h41, 8'hF0, 2'h3, 1'b0);
    sw(8'h00, 8'h30, 2'h2, 1'b1);
    sw(8'h00, 8'h00, 2'h0, 1'b1);
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    t_reset;
    t_setup;
    t_switch;
    wrap_up;
  end
endmodule
